// ===== rtl/cplt_pkg.sv
/*
 * Constants for the component link parameter table interpreter.
 * Assumes a 16-bit word-wide data memory reached by a single read port.
 */
package cplt_pkg;
	// ------------------------------------------------------------
	// Common area and table layout
	// ------------------------------------------------------------
	localparam int unsigned WRITE_AREA_BASE   = 9;
	localparam int unsigned WRITE_AREA_STRIDE = 3;
	localparam int unsigned TBL_COUNT_OFS     = 0;
	localparam int unsigned TBL_WORD1_OFS     = 1;
	localparam int unsigned TBL_START_OFS     = 2;
	localparam int unsigned VAR_TYPE_BASE     = 1;
	localparam int unsigned VAR_ADDR_BASE     = 2;
	localparam int unsigned VAR_MAX           = 12;
	localparam logic [15:0] READ_COUNT_MIN    = 16'h0001;
	localparam logic [15:0] WRITE_COUNT_MIN   = 16'h0000;
	localparam logic [15:0] COUNT_MAX         = 16'h0012;
	localparam logic [15:0] TYPE_MIN          = 16'h00C0;
	localparam logic [15:0] TYPE_MAX          = 16'h00CF;
	localparam logic [15:0] OPCMD_OFF         = 16'h0000;
	localparam logic [15:0] OPCMD_ON          = 16'h0001;
	localparam logic [1:0]  PROTO_NONE        = 2'h0;
	localparam logic [1:0]  PROTO_LEGACY      = 2'h1;
	localparam logic [1:0]  PROTO_VARADDR     = 2'h2;

	// ------------------------------------------------------------
	// Register map (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0]  REG_CTRL      = 8'h00;
	localparam logic [7:0]  REG_STATUS    = 8'h04;
	localparam logic [7:0]  REG_READ_BASE = 8'h08;
	localparam logic [7:0]  REG_RESULT    = 8'h0C;
	localparam logic [7:0]  REG_WRSTART   = 8'h10;
	localparam logic [7:0]  REG_RDSTART   = 8'h14;
	localparam logic [7:0]  REG_ERRINFO   = 8'h18;
	localparam logic [7:0]  REG_ITEM      = 8'h1C;
	localparam int unsigned CTRL_GO_BIT   = 0;
	localparam int unsigned CTRL_DIR_BIT  = 1;
	localparam int unsigned CTRL_PROTO_LO = 2;
	localparam int unsigned CTRL_UNIT_LO  = 8;
	localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

	typedef enum logic [3:0] {
		CPLT_ST_IDLE,
		CPLT_ST_AREA,
		CPLT_ST_TBL0,
		CPLT_ST_TBL1,
		CPLT_ST_TBL2,
		CPLT_ST_VTYPE,
		CPLT_ST_VADDR,
		CPLT_ST_SEND,
		CPLT_ST_DONE
	} cplt_state_e;
endpackage : cplt_pkg

// ===== rtl/cplt_top.sv
/*
 * Parameter-table validator and interpreter for one serial component link.
 * Software selects a unit, protocol and direction and sets go; the block
 * fetches the unit's configuration words from data memory, checks them and
 * hands each variable's type and address to the link transmitter.
 * Assumes data memory answers a read one cycle after mem_rd_en, and that the
 * transmitter takes a word on each cycle in which item_valid and item_ready
 * are both high.
 */
// ------------------------------------------------------------
// Summary of operation
// - Write-area word at offset 9 + 3*unit.
// - Legacy mode: word is write data start.
// - Variable mode: word points to write table.
// - Non-BCD start address is syntax error.
// - Read table: count, reserved, start, pairs.
// - Read variables 1..N, N 1 to 12.
// - Read count outside 1..12 is error.
// - Read data stored from table offset 2.
// - Variable n: type 1+2n, address 2+2n.
// - Type outside C0..CF hex is error.
// - Type and address sent unchanged.
// - Write table: count, opcmd, start, pairs.
// - Write variables 1..N, N 0 to 12.
// - Zero count writes only operation command.
// - Write count outside 0..12 is error.
// - Opcmd 0 suppresses, 1 sends command.
// - Opcmd other than 0 or 1 is error.
// - Protocol 1 legacy, 2 variable, 0 none.
// ------------------------------------------------------------
`timescale 1ns/1ns
`default_nettype none
module cplt_top #(
	parameter int unsigned MEM_AW = 14
) (
	input  wire logic                 clock,
	input  wire logic                 reset,
	input  wire logic [7:0]           avs_address,
	input  wire logic                 avs_read,
	input  wire logic                 avs_write,
	input  wire logic [31:0]          avs_writedata,
	output logic      [31:0]          avs_readdata,
	output logic                      avs_waitrequest,
	output logic      [MEM_AW-1:0]    mem_addr,
	output logic                      mem_rd_en,
	input  wire logic [15:0]          mem_rdata,
	output logic      [15:0]          item_word,
	output logic                      item_valid,
	input  wire logic                 item_ready,
	output logic                      op_cmd_send
);
	import cplt_pkg::*;

	initial begin
		if (MEM_AW < 14 || MEM_AW > 16)
			$error("MEM_AW must hold 0 to 9999");
	end

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic is_bcd(input logic [15:0] w);
		is_bcd = (w[3:0] < 4'hA) && (w[7:4] < 4'hA) &&
			(w[11:8] < 4'hA) && (w[15:12] < 4'hA);
	endfunction : is_bcd

	function automatic logic [15:0] bcd2bin(input logic [15:0] w);
		bcd2bin = 16'(w[15:12]) * 16'd1000 + 16'(w[11:8]) * 16'd100 +
			16'(w[7:4]) * 16'd10 + 16'(w[3:0]);
	endfunction : bcd2bin

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	cplt_state_e      state_r;
	logic             dir_write_r;
	logic [1:0]       proto_r;
	logic [5:0]       unit_r;
	logic [15:0]      read_base_r;
	logic [15:0]      table_base_r;
	logic [15:0]      wr_start_r;
	logic [15:0]      rd_start_r;
	logic [15:0]      count_r;
	logic [3:0]       var_r;
	logic             wait_r;
	logic             opcmd_r;
	logic             busy_r;
	logic             done_r;
	logic             err_r;
	logic [3:0]       err_code_r;
	logic [15:0]      sent_r;
	logic             go_nxt;
	logic [15:0]      rd_word;
	logic [4:0]       tbl_ofs;

	assign go_nxt = avs_write && !avs_waitrequest &&
		avs_address == REG_CTRL && avs_writedata[CTRL_GO_BIT] && !busy_r;
	assign rd_word = mem_rdata;
	// Table offsets of the current variable's type and address.
	assign tbl_ofs = (state_r == CPLT_ST_VADDR) ?
		5'(VAR_ADDR_BASE) + {var_r, 1'b0} :
		5'(VAR_TYPE_BASE) + {var_r, 1'b0};

	// ------------------------------------------------------------
	// Register bus
	// ------------------------------------------------------------
	// One wait cycle per access keeps readdata registered.
	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
			avs_waitrequest <= 1'b1;
		else if ((avs_read || avs_write) && avs_waitrequest)
			avs_waitrequest <= 1'b0;
		else
			avs_waitrequest <= 1'b1;
	end

	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
			avs_readdata <= 32'h0000_0000;
		else if (avs_read && avs_waitrequest)
			unique case (avs_address)
				REG_CTRL:      avs_readdata <= {18'h0, unit_r, 4'h0,
					proto_r, dir_write_r, 1'b0};
				REG_STATUS:    avs_readdata <= {29'h0, err_r, done_r, busy_r};
				REG_READ_BASE: avs_readdata <= {16'h0, read_base_r};
				REG_RESULT:    avs_readdata <= {16'h0, sent_r};
				REG_WRSTART:   avs_readdata <= {16'h0, wr_start_r};
				REG_RDSTART:   avs_readdata <= {16'h0, rd_start_r};
				REG_ERRINFO:   avs_readdata <= {28'h0, err_code_r};
				REG_ITEM:      avs_readdata <= {12'h0, 4'(var_r), count_r};
				default:       avs_readdata <= UNMAPPED_DATA;
			endcase
	end

	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			dir_write_r <= 1'b0;
			proto_r     <= PROTO_NONE;
			unit_r      <= 6'h00;
			read_base_r <= 16'h0000;
		end
		else if (avs_write && !avs_waitrequest && !busy_r)
		begin
			if (avs_address == REG_CTRL)
			begin
				dir_write_r <= avs_writedata[CTRL_DIR_BIT];
				proto_r     <= avs_writedata[CTRL_PROTO_LO +: 2];
				unit_r      <= avs_writedata[CTRL_UNIT_LO +: 6];
			end
			else if (avs_address == REG_READ_BASE)
				read_base_r <= avs_writedata[15:0];
		end
	end

	// ------------------------------------------------------------
	// Table walk
	// ------------------------------------------------------------
	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			state_r      <= CPLT_ST_IDLE;
			busy_r       <= 1'b0;
			done_r       <= 1'b0;
			err_r        <= 1'b0;
			err_code_r   <= 4'h0;
			wait_r       <= 1'b0;
			mem_rd_en    <= 1'b0;
			mem_addr     <= '0;
			table_base_r <= 16'h0000;
			wr_start_r   <= 16'h0000;
			rd_start_r   <= 16'h0000;
			count_r      <= 16'h0000;
			var_r        <= 4'h0;
			item_word    <= 16'h0000;
			item_valid   <= 1'b0;
			op_cmd_send  <= 1'b0;
			sent_r       <= 16'h0000;
			opcmd_r      <= 1'b0;
		end
		else
		begin
			mem_rd_en   <= 1'b0;
			op_cmd_send <= 1'b0;
			unique case (state_r)
				CPLT_ST_IDLE:
				begin
					if (go_nxt)
					begin
						done_r <= 1'b0;
						err_r  <= 1'b0;
						err_code_r <= 4'h0;
						sent_r <= 16'h0000;
						opcmd_r <= 1'b0;
						var_r  <= 4'h0;
						if (avs_writedata[CTRL_PROTO_LO +: 2] == PROTO_NONE)
							done_r <= 1'b1;
						else
						begin
							busy_r    <= 1'b1;
							state_r   <= CPLT_ST_AREA;
							mem_rd_en <= 1'b1;
							wait_r    <= 1'b1;
							// Write direction uses the write-area word,
							// read direction the word just below it.
							mem_addr <= MEM_AW'(read_base_r +
								16'(WRITE_AREA_BASE) +
								16'(WRITE_AREA_STRIDE) *
								16'(avs_writedata[CTRL_UNIT_LO +: 6]) -
								16'(!avs_writedata[CTRL_DIR_BIT]));
						end
					end
				end
				CPLT_ST_AREA:
				begin
					wait_r <= 1'b0;
					if (!wait_r)
					begin
						if (!is_bcd(rd_word))
						begin
							err_code_r <= 4'h1;
							state_r <= CPLT_ST_DONE;
						end
						else if (proto_r == PROTO_LEGACY)
						begin
							// Word is the data start itself.
							wr_start_r <= rd_word;
							state_r <= CPLT_ST_DONE;
						end
						else
						begin
							table_base_r <= bcd2bin(rd_word);
							mem_addr <= MEM_AW'(bcd2bin(rd_word) +
								16'(TBL_COUNT_OFS));
							mem_rd_en <= 1'b1;
							wait_r <= 1'b1;
							state_r <= CPLT_ST_TBL0;
						end
					end
				end
				CPLT_ST_TBL0:
				begin
					wait_r <= 1'b0;
					if (!wait_r)
					begin
						count_r <= rd_word;
						if (!is_bcd(rd_word) || rd_word > COUNT_MAX ||
							(!dir_write_r && rd_word < READ_COUNT_MIN) ||
							(dir_write_r && rd_word < WRITE_COUNT_MIN))
						begin
							err_code_r <= dir_write_r ? 4'h3 : 4'h2;
							state_r <= CPLT_ST_DONE;
						end
						else
						begin
							mem_addr <= MEM_AW'(table_base_r +
								16'(TBL_WORD1_OFS));
							mem_rd_en <= 1'b1;
							wait_r <= 1'b1;
							state_r <= CPLT_ST_TBL1;
						end
					end
				end
				CPLT_ST_TBL1:
				begin
					wait_r <= 1'b0;
					if (!wait_r)
					begin
						// The read-table word is reserved and not checked.
						if (dir_write_r && rd_word != OPCMD_OFF &&
							rd_word != OPCMD_ON)
						begin
							err_code_r <= 4'h4;
							state_r <= CPLT_ST_DONE;
						end
						else
						begin
							opcmd_r <= dir_write_r && rd_word == OPCMD_ON;
							mem_addr <= MEM_AW'(table_base_r +
								16'(TBL_START_OFS));
							mem_rd_en <= 1'b1;
							wait_r <= 1'b1;
							state_r <= CPLT_ST_TBL2;
						end
					end
				end
				CPLT_ST_TBL2:
				begin
					wait_r <= 1'b0;
					if (!wait_r)
					begin
						if (!is_bcd(rd_word))
						begin
							err_code_r <= 4'h5;
							state_r <= CPLT_ST_DONE;
						end
						else
						begin
							if (dir_write_r)
								wr_start_r <= rd_word;
							else
								rd_start_r <= rd_word;
							if (count_r == 16'h0000)
								state_r <= CPLT_ST_DONE;
							else
							begin
								var_r <= 4'h1;
								mem_addr <= MEM_AW'(table_base_r + 16'h0003);
								mem_rd_en <= 1'b1;
								wait_r <= 1'b1;
								state_r <= CPLT_ST_VTYPE;
							end
						end
					end
				end
				CPLT_ST_VTYPE, CPLT_ST_VADDR:
				begin
					wait_r <= 1'b0;
					if (!wait_r && !item_valid)
					begin
						if (state_r == CPLT_ST_VTYPE &&
							(rd_word < TYPE_MIN || rd_word > TYPE_MAX))
						begin
							err_code_r <= 4'h6;
							state_r <= CPLT_ST_DONE;
						end
						else
						begin
							item_word  <= rd_word;
							item_valid <= 1'b1;
						end
					end
					else if (item_valid && item_ready)
					begin
						item_valid <= 1'b0;
						sent_r <= sent_r + 16'h0001;
						if (state_r == CPLT_ST_VTYPE)
						begin
							mem_addr <= MEM_AW'(table_base_r +
								16'(tbl_ofs) + 16'h0001);
							state_r <= CPLT_ST_VADDR;
							mem_rd_en <= 1'b1;
							wait_r <= 1'b1;
						end
						else if (16'(var_r) == 16'(bcd2bin(count_r)))
							state_r <= CPLT_ST_DONE;
						else
						begin
							var_r <= var_r + 4'h1;
							mem_addr <= MEM_AW'(table_base_r +
								16'(tbl_ofs) + 16'h0001);
							state_r <= CPLT_ST_VTYPE;
							mem_rd_en <= 1'b1;
							wait_r <= 1'b1;
						end
					end
				end
				CPLT_ST_DONE:
				begin
					busy_r <= 1'b0;
					done_r <= 1'b1;
					err_r  <= err_code_r != 4'h0;
					// A table with an error sends no operation command.
					if (err_code_r == 4'h0 && dir_write_r &&
						proto_r == PROTO_VARADDR && opcmd_r)
						op_cmd_send <= 1'b1;
					state_r <= CPLT_ST_IDLE;
				end
				default:
					state_r <= CPLT_ST_IDLE;
			endcase
		end
	end
endmodule : cplt_top
`default_nettype wire

// ===== verif/cplt_props.sv
/* Port checker for cplt_top.
   Assumes the bench holds each bus request until waitrequest is low. */
`timescale 1ns/1ns
`default_nettype none
module cplt_props
	import cplt_pkg::*;
(
	input wire logic        clock,
	input wire logic        reset,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic        avs_waitrequest,
	input wire logic        mem_rd_en,
	input wire logic [15:0] item_word,
	input wire logic        item_valid,
	input wire logic        item_ready,
	input wire logic        op_cmd_send
);
	logic addr_phase_r;

	// Items alternate type then address, so the phase marks type words.
	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
			addr_phase_r <= 1'b0;
		else if (item_valid && item_ready)
			addr_phase_r <= ~addr_phase_r;
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);

	a_read_answer: assert property
		($rose(avs_read) |=> !avs_waitrequest) else $error("read late");
	a_write_answer: assert property
		($rose(avs_write) |=> !avs_waitrequest) else $error("write late");
	a_wait_single: assert property
		(!avs_waitrequest |=> avs_waitrequest) else $error("wait low twice");
	a_item_hold: assert property
		(item_valid && !item_ready |=> item_valid && $stable(item_word))
		else $error("item dropped");
	a_type_range: assert property
		(item_valid && !addr_phase_r |-> item_word inside {[TYPE_MIN:TYPE_MAX]})
		else $error("bad type sent");
	a_item_cause: assert property
		($rose(item_valid) |-> $past(mem_rd_en, 2)) else $error("item early");
	a_opcmd_pulse: assert property
		(op_cmd_send |=> !op_cmd_send) else $error("opcmd long");
	a_opcmd_alone: assert property
		(op_cmd_send |-> !item_valid) else $error("opcmd with item");

	c_item: cover property (item_valid && item_ready);
	c_stall: cover property (item_valid && !item_ready);
	c_opcmd: cover property (op_cmd_send);
endmodule : cplt_props

bind cplt_top cplt_props i_cplt_props (.clock(clock), .reset(reset),
	.avs_read(avs_read), .avs_write(avs_write),
	.avs_waitrequest(avs_waitrequest), .mem_rd_en(mem_rd_en),
	.item_word(item_word), .item_valid(item_valid),
	.item_ready(item_ready), .op_cmd_send(op_cmd_send));
`default_nettype wire

// ===== verif/cplt_partner.sv
/* Data memory and link transmitter model facing cplt_top.
   Assumes the bench fills mem directly between runs. */
`timescale 1ns/1ns
`default_nettype none
module cplt_partner #(
	parameter int unsigned MEM_AW = 14
) (
	input wire logic              clock,
	input wire logic              reset,
	input wire logic [MEM_AW-1:0] mem_addr,
	input wire logic              mem_rd_en,
	output logic      [15:0]      mem_rdata,
	output logic                  item_ready,
	input wire logic              slow
);
	logic [15:0] mem [0:(1<<MEM_AW)-1];

	initial foreach (mem[i]) mem[i] = 16'h0000;

	// Read data is held until the next strobe.
	always @(posedge clock)
		if (mem_rd_en)
			mem_rdata <= mem[mem_addr];

	// Slow mode drops ready every other cycle to stretch each item.
	always @(posedge clock or posedge reset)
		if (reset)
			item_ready <= 1'b0;
		else
			item_ready <= slow ? ~item_ready : 1'b1;
endmodule : cplt_partner
`default_nettype wire

// ===== verif/test_component_link_param_table.sv
/* Self-checking bench for cplt_top.
   Assumes cplt_partner stands in for data memory and the transmitter. */
`timescale 1ns/1ns
`default_nettype none
module test_component_link_param_table;
	import cplt_pkg::*;
	localparam int BASE = 256;
	logic        clock, reset, avs_read, avs_write, avs_waitrequest;
	logic        mem_rd_en, item_valid, item_ready, op_cmd_send, slow;
	logic [7:0]  avs_address;
	logic [31:0] avs_writedata, avs_readdata, q;
	logic [13:0] mem_addr;
	logic [15:0] mem_rdata, item_word;
	logic [15:0] got[$];
	int          err_count, checks, cyc, ops;

	cplt_top #(.MEM_AW(14)) i_cplt_top (.clock(clock), .reset(reset),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.mem_addr(mem_addr), .mem_rd_en(mem_rd_en), .mem_rdata(mem_rdata),
		.item_word(item_word), .item_valid(item_valid),
		.item_ready(item_ready), .op_cmd_send(op_cmd_send));
	cplt_partner #(.MEM_AW(14)) i_cplt_partner (.clock(clock),
		.reset(reset), .mem_addr(mem_addr), .mem_rd_en(mem_rd_en),
		.mem_rdata(mem_rdata), .item_ready(item_ready), .slow(slow));

	initial
	begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end

	always @(posedge clock)
	begin
		if (item_valid === 1'b1 && item_ready === 1'b1)
			got.push_back(item_word);
		if (op_cmd_send === 1'b1)
			ops++;
		cyc++;
		if (cyc == 20000)
		begin
			err_count++;
			end_sim;
		end
	end

	task automatic end_sim;
		$display("errors %0d checks %0d", err_count, checks);
		if (err_count == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : end_sim

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("wrong value at %0t: %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r);
		@(posedge clock);
		avs_address   <= a;
		avs_writedata <= d;
		avs_read      <= !wr;
		avs_write     <= wr;
		do @(posedge clock); while (avs_waitrequest !== 1'b0);
		r = avs_readdata;
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] r;
		bus(1'b0, a, 32'h0000_0000, r);
		check(r, exp);
	endtask : rd

	// ----------------------------------------
	// One unit run: tables, go, then results
	// ----------------------------------------
	task automatic run(input logic dir, input logic [1:0] proto,
		input logic [5:0] unit, input logic [15:0] area, cnt, w1,
		input int sh, badv, nexp, input logic [3:0] code, input logic op);
		logic [31:0] r;
		int          n;
		i_cplt_partner.mem[BASE + (dir ? 9 : 8) + 3 * unit] = area;
		i_cplt_partner.mem[2000] = cnt;
		i_cplt_partner.mem[2001] = w1;
		i_cplt_partner.mem[2002] = (code == 4'h5) ? 16'h05A0 : 16'h0500;
		for (n = 1; n <= 12; n++)
		begin
			i_cplt_partner.mem[2001 + 2 * n] = (n == badv) ? 16'h00BF :
				16'h00C0 + 16'((n - 1 + sh) % 16);
			i_cplt_partner.mem[2002 + 2 * n] = 16'h1000 + 16'(n);
		end
		got.delete();
		ops = 0;
		bus(1'b1, REG_CTRL, {18'h0, unit, 4'h0, proto, dir, 1'b1}, r);
		do bus(1'b0, REG_STATUS, 32'h0, r); while (r[1] !== 1'b1);
		check({29'h0, r[2:0]}, {29'h0, code != 4'h0, 2'b10});
		if (code != 4'h0)
			rd(REG_ERRINFO, {28'h0, code});
		else if (proto == PROTO_LEGACY)
			rd(REG_WRSTART, {16'h0, area});
		else if (proto != PROTO_NONE)
			rd(dir ? REG_WRSTART : REG_RDSTART, 32'h0000_0500);
		check(32'(got.size()), 32'(2 * nexp));
		rd(REG_RESULT, 32'(2 * nexp));
		rd(REG_CTRL, {18'h0, unit, 4'h0, proto, dir, 1'b0});
		for (n = 0; n < nexp && n < got.size() / 2; n++)
		begin
			check({16'h0, got[2 * n]}, 32'h00C0 + 32'((n + sh) % 16));
			check({16'h0, got[2 * n + 1]}, 32'h1001 + 32'(n));
		end
		check(32'(ops), {31'h0, op});
	endtask : run

	initial
	begin
		reset         = 1'b1;
		avs_address   = 8'h00;
		avs_read      = 1'b0;
		avs_write     = 1'b0;
		avs_writedata = 32'h0;
		slow          = 1'b0;
		err_count     = 0;
		checks        = 0;
		cyc           = 0;
		repeat (3) @(posedge clock);
		reset <= 1'b0;
		bus(1'b1, REG_READ_BASE, 32'h0000_0100, q);
		rd(REG_READ_BASE, 32'h0000_0100);
		rd(8'hFC, UNMAPPED_DATA);
		run(0, PROTO_VARADDR, 1, 16'h2000, 16'h0012, 0, 0, 0, 12, 0, 0);
		slow <= 1'b1;
		run(1, PROTO_VARADDR, 2, 16'h2000, 16'h0012, 0, 4, 0, 12, 0, 0);
		slow <= 1'b0;
		run(1, PROTO_VARADDR, 3, 16'h2000, 16'h0003, 1, 0, 0, 3, 0, 1);
		run(1, PROTO_VARADDR, 11, 16'h2000, 16'h0001, 0, 0, 0, 0, 5, 0);
		run(1, PROTO_VARADDR, 31, 16'h2000, 16'h0000, 1, 0, 0, 0, 0, 1);
		run(1, PROTO_VARADDR, 4, 16'h2000, 16'h0013, 0, 0, 0, 0, 3, 0);
		run(1, PROTO_VARADDR, 5, 16'h2000, 16'h0000, 2, 0, 0, 0, 4, 0);
		run(0, PROTO_VARADDR, 6, 16'h2000, 16'h0000, 0, 0, 0, 0, 2, 0);
		run(0, PROTO_VARADDR, 7, 16'h2000, 16'h0013, 0, 0, 0, 0, 2, 0);
		run(1, PROTO_VARADDR, 8, 16'h2000, 16'h0002, 0, 0, 2, 1, 6, 0);
		run(1, PROTO_VARADDR, 9, 16'h20A0, 16'h0001, 0, 0, 0, 0, 1, 0);
		run(1, PROTO_LEGACY, 0, 16'h1234, 16'h0001, 0, 0, 0, 0, 0, 0);
		run(1, PROTO_NONE, 10, 16'h2000, 16'h0001, 0, 0, 0, 0, 0, 0);
		end_sim;
	end
endmodule : test_component_link_param_table
`default_nettype wire
